// file: verilog/tpls_tray_sense.v
// tpls_tray_sense.v: size, level, near end, empty and lift control for three trays
// assumes sensor pins are raw asynchronous levels and the motor driver takes level commands
`timescale 1ns/1ns
`default_nettype none
`include "tpls_defines.vh"

module tpls_tray_sense #(
	parameter TRAYS = 3,
	parameter REVERSE_CYCLES = `TPLS_REVERSE_CYCLES,
	parameter FILTER_SAMPLES = `TPLS_FILTER_SAMPLES
) (
	input wire clk,
	input wire reset,
	input wire region_north_america,
	input wire [TRAYS-1:0] width_sense_a,
	input wire [TRAYS-1:0] width_sense_b,
	input wire [TRAYS-1:0] width_sense_c,
	input wire [TRAYS-1:0] length_sense,
	input wire [TRAYS*4-1:0] height_sense_n,
	input wire [TRAYS-1:0] paper_end_light,
	input wire [TRAYS-1:0] lift_sense_active,
	input wire [TRAYS-1:0] manual_size_valid,
	input wire [TRAYS*`TPLS_SIZE_W-1:0] manual_size,
	output reg [TRAYS*`TPLS_SIZE_W-1:0] size_code,
	output reg [TRAYS-1:0] size_valid,
	output reg [TRAYS*`TPLS_LEVEL_W-1:0] level_pct,
	output reg [TRAYS-1:0] near_end,
	output reg [TRAYS-1:0] tray_empty,
	output reg [TRAYS-1:0] lift_forward,
	output reg [TRAYS-1:0] lift_reverse
);
	localparam NBITS = TRAYS * 10;

	// ==========================================
	// size decode, returns {auto_ok, code}
	function [`TPLS_SIZE_W:0] decode_size;
		input [3:0] pattern;
		input na;
		begin
			case (pattern)
				4'b0001: decode_size = {1'b1, `TPLS_SIZE_LARGE};
				4'b0011: decode_size = {1'b1, `TPLS_SIZE_A3_SEF};
				4'b0010: decode_size = {1'b1, `TPLS_SIZE_A4_LEF};
				4'b0101: decode_size = {1'b1, `TPLS_SIZE_DLT_SEF};
				4'b0100: decode_size = {1'b1, `TPLS_SIZE_LT_LEF};
				4'b0111: decode_size = {1'b1, `TPLS_SIZE_B4_SEF};
				4'b0110: decode_size = {1'b1, `TPLS_SIZE_B5_LEF};
				4'b1100: decode_size = {1'b1, `TPLS_SIZE_A5_SEF};
				4'b1110: decode_size = {1'b1, `TPLS_SIZE_HLT_SEF};
				4'b1001: decode_size = na ? {1'b1, `TPLS_SIZE_LT_SEF} : {1'b1, `TPLS_SIZE_A4_SEF};
				4'b1000: decode_size = na ? {1'b1, `TPLS_SIZE_HLT_LEF} : {1'b1, `TPLS_SIZE_A5_LEF};
				4'b1011: decode_size = {1'b1, `TPLS_SIZE_F_SEF};
				default: decode_size = {1'b0, `TPLS_SIZE_NONE};
			endcase
		end
	endfunction

	// level from active-low height sensors {s4,s3,s2,s1}
	function [`TPLS_LEVEL_W-1:0] decode_level;
		input [3:0] on;
		begin
			if (on[1]) begin
				decode_level = `TPLS_LEVEL_10;
			end else if (on[2]) begin
				decode_level = `TPLS_LEVEL_30;
			end else if (on[3]) begin
				decode_level = `TPLS_LEVEL_70;
			end else begin
				decode_level = `TPLS_LEVEL_FULL;
			end
		end
	endfunction

	// ==========================================
	// input conditioning for all sensors of all trays
	wire [NBITS-1:0] raw_bits;
	wire [NBITS-1:0] clean_bits;
	wire [NBITS-1:0] init_bits;

	genvar t;
	generate
		for (t = 0; t < TRAYS; t = t + 1) begin : g_pack
			// per tray: {lift, end_light, h[3:0], len, wc, wb, wa}
			assign raw_bits[t*10 +: 10] = {lift_sense_active[t], paper_end_light[t], height_sense_n[t*4 +: 4],
				length_sense[t], width_sense_c[t], width_sense_b[t], width_sense_a[t]};
			assign init_bits[t*10 +: 10] = `TPLS_SENSE_IDLE; // lift sensor idles low: no forward drive after reset
		end
	endgenerate

	tpls_filter #(
		.WIDTH(NBITS),
		.SAMPLES(FILTER_SAMPLES)
	) u_filter (
		.clk(clk),
		.reset(reset),
		.raw(raw_bits),
		.init_value(init_bits),
		.clean(clean_bits)
	);

	reg na_sync_a;
	reg na_sync_b;

	// region strap is a pin too
	always @(posedge clk) begin
		if (reset) begin
			na_sync_a <= 1'b0;
			na_sync_b <= 1'b0;
		end else begin
			na_sync_a <= region_north_america;
			na_sync_b <= na_sync_a;
		end
	end

	// ==========================================
	// per-tray decode and lift control
	generate
		for (t = 0; t < TRAYS; t = t + 1) begin : g_tray
			wire [9:0] s = clean_bits[t*10 +: 10];
			wire [3:0] pattern = {s[0], s[1], s[2], s[3]};
			wire [`TPLS_SIZE_W:0] dec = decode_size(pattern, na_sync_b);
			wire [3:0] height_on = ~s[7:4];
			wire end_dark = ~s[8];
			wire lift_on = s[9];
			reg [1:0] state;
			reg [31:0] rev_count;
			reg end_seen;

			// outputs from filtered sensors
			always @(posedge clk) begin
				if (reset) begin
					size_code[t*`TPLS_SIZE_W +: `TPLS_SIZE_W] <= `TPLS_SIZE_NONE;
					size_valid[t] <= 1'b0;
					level_pct[t*`TPLS_LEVEL_W +: `TPLS_LEVEL_W] <= `TPLS_LEVEL_FULL;
					near_end[t] <= 1'b0;
					tray_empty[t] <= 1'b0;
				end else begin
					if (manual_size_valid[t]) begin
						size_code[t*`TPLS_SIZE_W +: `TPLS_SIZE_W] <= manual_size[t*`TPLS_SIZE_W +: `TPLS_SIZE_W];
						size_valid[t] <= 1'b1;
					end else begin
						size_code[t*`TPLS_SIZE_W +: `TPLS_SIZE_W] <= dec[`TPLS_SIZE_W-1:0];
						size_valid[t] <= dec[`TPLS_SIZE_W];
					end
					level_pct[t*`TPLS_LEVEL_W +: `TPLS_LEVEL_W] <= decode_level(height_on);
					near_end[t] <= height_on[0];
					tray_empty[t] <= end_dark;
				end
			end

			// lift motor: forward while lift sensor active and tray not empty, reverse 2 s on paper end
			always @(posedge clk) begin
				if (reset) begin
					state <= `TPLS_LIFT_IDLE;
					rev_count <= 32'h0000_0000;
					end_seen <= 1'b0;
					lift_forward[t] <= 1'b0;
					lift_reverse[t] <= 1'b0;
				end else begin
					end_seen <= end_dark;
					case (state)
						`TPLS_LIFT_IDLE, `TPLS_LIFT_UP: begin
							if (end_dark && !end_seen) begin
								state <= `TPLS_LIFT_DOWN;
								rev_count <= 32'h0000_0000;
								lift_forward[t] <= 1'b0;
								lift_reverse[t] <= 1'b1;
							end else if (lift_on && !end_dark) begin
								state <= `TPLS_LIFT_UP;
								lift_forward[t] <= 1'b1;
								lift_reverse[t] <= 1'b0;
							end else begin
								state <= `TPLS_LIFT_IDLE;
								lift_forward[t] <= 1'b0;
								lift_reverse[t] <= 1'b0;
							end
						end
						`TPLS_LIFT_DOWN: begin
							if (rev_count >= REVERSE_CYCLES - 1) begin
								state <= `TPLS_LIFT_DONE;
								lift_reverse[t] <= 1'b0;
							end else begin
								rev_count <= rev_count + 32'h0000_0001;
							end
						end
						`TPLS_LIFT_DONE: begin
							if (!end_dark) begin
								state <= `TPLS_LIFT_IDLE;
							end
						end
						default: begin
							state <= `TPLS_LIFT_IDLE;
						end
					endcase
				end
			end
		end
	endgenerate
endmodule // tpls_tray_sense

`default_nettype wire

// file: verilog/tpls_defines.vh
// tpls_defines.vh: constants for the tray paper size and level sense block
// assumes a 100 MHz clock; included by bare name from verilog/ sources
// ==========================================
// How it works
// - each of three trays samples three width inputs and one length input and classifies the paper size from them.
// - a high sensor level means the sensor is off and a low level means it is on; here the lift sensor input is active high.
// - codes LLLH, LLHH, LLHL, LHLH, LHLL give large, A3 SEF, A4 LEF, DLT SEF and LT LEF.
// - codes LHHH, LHHL, HHLL, HHHL give B4 SEF, B5 LEF, A5 SEF and HLT SEF in both regions.
// - HLLH is A4 SEF or LT SEF and HLLL is A5 LEF or HLT LEF by region, HLHH is F SEF everywhere.
// - a size not detected automatically in the region is reported only when the operator has set it manually.
// - four height sensor inputs are watched per tray, the same for every tray.
// - level is 100% with no height sensor, 70% past sensor 4, 30% past sensor 3, 10% past sensor 2.
// - near end is flagged when the actuator is in the gap of height sensor 1.
// - a tray is empty when its reflective end sensor loses the reflected light.
// - on running out of paper the lift motor runs in reverse for 2 seconds and then stops.
// - when the lift sensor becomes active the lift motor runs forward until it deactivates; here forward is held off while the tray is empty.
`ifndef TPLS_DEFINES_VH
`define TPLS_DEFINES_VH

// size codes, {w_a, w_b, w_c, len} with 1 = high = off
`define TPLS_SIZE_NONE 5'h00
`define TPLS_SIZE_LARGE 5'h01
`define TPLS_SIZE_A3_SEF 5'h02
`define TPLS_SIZE_A4_LEF 5'h03
`define TPLS_SIZE_DLT_SEF 5'h04
`define TPLS_SIZE_LT_LEF 5'h05
`define TPLS_SIZE_B4_SEF 5'h06
`define TPLS_SIZE_B5_LEF 5'h07
`define TPLS_SIZE_A4_SEF 5'h08
`define TPLS_SIZE_LT_SEF 5'h09
`define TPLS_SIZE_A5_LEF 5'h0A
`define TPLS_SIZE_HLT_LEF 5'h0B
`define TPLS_SIZE_B5_SEF 5'h0C
`define TPLS_SIZE_F_SEF 5'h0D
`define TPLS_SIZE_A5_SEF 5'h0E
`define TPLS_SIZE_HLT_SEF 5'h0F
`define TPLS_SIZE_W 5

// level percentages reported
`define TPLS_LEVEL_FULL 7'h64
`define TPLS_LEVEL_70 7'h46
`define TPLS_LEVEL_30 7'h1E
`define TPLS_LEVEL_10 7'h0A
`define TPLS_LEVEL_W 7

// timing
`define TPLS_CLK_HZ 100000000
`define TPLS_REVERSE_MS 2000
`define TPLS_REVERSE_CYCLES (`TPLS_REVERSE_MS * (`TPLS_CLK_HZ / 1000))
`define TPLS_FILTER_SAMPLES 4

// idle levels of one tray {lift, end_light, h[3:0], len, wc, wb, wa}: lift sensor low, the rest high
`define TPLS_SENSE_IDLE 10'h1FF

// lift state codes
`define TPLS_LIFT_IDLE 2'b00
`define TPLS_LIFT_UP 2'b01
`define TPLS_LIFT_DOWN 2'b10
`define TPLS_LIFT_DONE 2'b11

`endif

// file: verilog/tpls_filter.v
// tpls_filter.v: two-flop synchroniser plus stability filter for a vector
// assumes asynchronous inputs and one clock
`timescale 1ns/1ns
`default_nettype none
`include "tpls_defines.vh"

module tpls_filter #(
	parameter WIDTH = 8,
	parameter SAMPLES = `TPLS_FILTER_SAMPLES
) (
	input wire clk,
	input wire reset,
	input wire [WIDTH-1:0] raw,
	input wire [WIDTH-1:0] init_value,
	output reg [WIDTH-1:0] clean
);
	reg [WIDTH-1:0] sync_a;
	reg [WIDTH-1:0] sync_b;
	reg [WIDTH-1:0] last;
	reg [7:0] stable_count;

	// ==========================================
	// synchronise, then accept a value held for SAMPLES+2 clocks
	always @(posedge clk) begin
		if (reset) begin
			sync_a <= init_value; // start at idle so reset brings no false change
			sync_b <= init_value;
			last <= init_value;
			stable_count <= 8'h00;
			clean <= init_value;
		end else begin
			sync_a <= raw;
			sync_b <= sync_a;
			last <= sync_b;
			if (sync_b != last) begin
				stable_count <= 8'h00;
			end else if (stable_count < SAMPLES[7:0]) begin
				stable_count <= stable_count + 8'h01;
			end else begin
				clean <= last;
			end
		end
	end
endmodule // tpls_filter

`default_nettype wire

// file: testbench/tpls_tray_sense_props.sv
// checker: motor, level and flag relations of the tray sense block
// assumes bind onto tpls_tray_sense, one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none
`include "tpls_defines.vh"
// ==========================================
// checker
module tpls_tray_sense_props #(parameter TRAYS = 3, parameter REVERSE_CYCLES = 50) (
	input wire clk,
	input wire reset,
	input wire [TRAYS-1:0] lift_sense_active,
	input wire [TRAYS*4-1:0] height_sense_n,
	input wire [TRAYS-1:0] paper_end_light,
	input wire [TRAYS-1:0] manual_size_valid,
	input wire [TRAYS*`TPLS_SIZE_W-1:0] manual_size,
	input wire [TRAYS*`TPLS_SIZE_W-1:0] size_code,
	input wire [TRAYS-1:0] size_valid,
	input wire [TRAYS*`TPLS_LEVEL_W-1:0] level_pct,
	input wire [TRAYS-1:0] near_end,
	input wire [TRAYS-1:0] tray_empty,
	input wire [TRAYS-1:0] lift_forward,
	input wire [TRAYS-1:0] lift_reverse
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [31:0] rev_cnt;
	// counts cycles of reverse drive on the first tray
	always @(posedge clk) begin
		rev_cnt <= (reset || !lift_reverse[0]) ? 32'h0000_0000 : rev_cnt + 32'h0000_0001;
	end
	motor_excl_a: assert property (!(lift_forward & lift_reverse))
		else $error("both motor directions on");
	rev_length_a: assert property ($fell(lift_reverse[0]) |-> rev_cnt == REVERSE_CYCLES)
		else $error("reverse drive length wrong");
	rev_start_a: assert property ($rose(tray_empty[0]) |-> lift_reverse[0])
		else $error("no reverse on empty");
	fwd_block_a: assert property (tray_empty[0] |-> !lift_forward[0])
		else $error("forward while empty");
	fwd_cause_a: assert property ($rose(lift_forward[0]) |-> $past(lift_sense_active[0], 4))
		else $error("forward without lift sensor");
	level_code_a: assert property (level_pct[6:0] inside {`TPLS_LEVEL_FULL, `TPLS_LEVEL_70, `TPLS_LEVEL_30,
		`TPLS_LEVEL_10})
		else $error("bad level code");
	near_cause_a: assert property ($rose(near_end[0]) |-> !$past(height_sense_n[0], 4))
		else $error("near end without sensor");
	manual_pass_a: assert property (manual_size_valid[0] && $past(manual_size_valid[0]) |->
		size_code[4:0] == $past(manual_size[4:0]) && size_valid[0])
		else $error("manual size not reported");
	empty_filter_a: assert property ($rose(tray_empty[0]) |->
		!$past(paper_end_light[0], 4) && !$past(paper_end_light[0], 8))
		else $error("empty without steady dark");
endmodule // tpls_tray_sense_props
bind tpls_tray_sense tpls_tray_sense_props #(.TRAYS(TRAYS), .REVERSE_CYCLES(REVERSE_CYCLES)) u_props (.clk(clk),
	.reset(reset), .lift_sense_active(lift_sense_active), .height_sense_n(height_sense_n),
	.paper_end_light(paper_end_light), .manual_size_valid(manual_size_valid), .manual_size(manual_size),
	.size_code(size_code), .size_valid(size_valid), .level_pct(level_pct), .near_end(near_end),
	.tray_empty(tray_empty), .lift_forward(lift_forward), .lift_reverse(lift_reverse));
`default_nettype wire

// file: testbench/tpls_lift_model.sv
// partner: lift sensor of each tray, cleared once the plate has risen
// assumes lift_forward is the level command to the lift motor
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// lift sensor model
module tpls_lift_model #(parameter TRAYS = 3) (
	input wire clk,
	input wire [TRAYS-1:0] level_drop,
	input wire [3:0] rise_time,
	input wire [TRAYS-1:0] lift_forward,
	output logic [TRAYS-1:0] lift_sense_active
);
	logic [3:0] run [TRAYS];
	initial begin
		lift_sense_active = '0;
		for (int t = 0; t < TRAYS; t++) run[t] = 4'h0;
	end
	// sensor goes active on a level drop, clears after rise_time forward cycles
	always @(posedge clk) begin
		for (int t = 0; t < TRAYS; t++) begin
			run[t] <= lift_forward[t] ? run[t] + 4'h1 : 4'h0;
			if (level_drop[t])
				lift_sense_active[t] <= 1'b1;
			else if (run[t] == rise_time)
				lift_sense_active[t] <= 1'b0;
		end
	end
endmodule // tpls_lift_model
`default_nettype wire

// file: testbench/tpls_tray_sense_tb_top.sv
// testbench: drives tray sensors, queues expected outputs, checks them
// assumes tpls_tray_sense and tpls_lift_model are compiled before it
`timescale 1ns/1ns
`default_nettype none
`include "tpls_defines.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("Error %0t mismatch", $time); end end
// ==========================================
// top
module tpls_tray_sense_tb_top;
	logic clk = 1'b0, reset = 1'b1, north = 1'b0;
	logic [2:0] width_sense_a = 3'h7, width_sense_b = 3'h7, width_sense_c = 3'h7, length_sense = 3'h7;
	logic [11:0] height_sense_n = 12'hfff;
	logic [2:0] paper_end_light = 3'h7, manual_size_valid = 3'h0, level_drop = 3'h0, lift_sense_active;
	logic [14:0] manual_size = 15'h0000, size_code;
	logic [2:0] size_valid, near_end, tray_empty, lift_forward, lift_reverse;
	logic [20:0] level_pct;
	integer errors = 0, check_count = 0, seed = 32'h35a7, n, rev_n = 0, fwd_n = 0;
	logic [44:0] q [$];
	event sample;
	tpls_tray_sense #(.REVERSE_CYCLES(50), .FILTER_SAMPLES(4)) DUT (.clk(clk), .reset(reset),
		.region_north_america(north), .width_sense_a(width_sense_a), .width_sense_b(width_sense_b),
		.width_sense_c(width_sense_c), .length_sense(length_sense), .height_sense_n(height_sense_n),
		.paper_end_light(paper_end_light), .lift_sense_active(lift_sense_active),
		.manual_size_valid(manual_size_valid), .manual_size(manual_size), .size_code(size_code),
		.size_valid(size_valid), .level_pct(level_pct), .near_end(near_end), .tray_empty(tray_empty),
		.lift_forward(lift_forward), .lift_reverse(lift_reverse));
	tpls_lift_model u_model (.clk(clk), .level_drop(level_drop), .rise_time(4'h6),
		.lift_forward(lift_forward), .lift_sense_active(lift_sense_active));
	always #5 clk = ~clk;
	// motor cycle counters of the first tray
	always @(posedge clk) begin
		rev_n += (lift_reverse[0] === 1'b1);
		fwd_n += (lift_forward[0] === 1'b1);
	end
	function automatic [4:0] ref_size(input [3:0] p, input r);
		case (p)
			4'h1: ref_size = `TPLS_SIZE_LARGE;
			4'h3: ref_size = `TPLS_SIZE_A3_SEF;
			4'h2: ref_size = `TPLS_SIZE_A4_LEF;
			4'h5: ref_size = `TPLS_SIZE_DLT_SEF;
			4'h4: ref_size = `TPLS_SIZE_LT_LEF;
			4'h7: ref_size = `TPLS_SIZE_B4_SEF;
			4'h6: ref_size = `TPLS_SIZE_B5_LEF;
			4'hC: ref_size = `TPLS_SIZE_A5_SEF;
			4'hE: ref_size = `TPLS_SIZE_HLT_SEF;
			4'h9: ref_size = r ? `TPLS_SIZE_LT_SEF : `TPLS_SIZE_A4_SEF;
			4'h8: ref_size = r ? `TPLS_SIZE_HLT_LEF : `TPLS_SIZE_A5_LEF;
			4'hB: ref_size = `TPLS_SIZE_F_SEF;
			default: ref_size = `TPLS_SIZE_NONE;
		endcase
	endfunction
	function automatic [44:0] expect_all();
		logic [14:0] sc;
		logic [2:0] sv, nb;
		logic [20:0] lv;
		logic [3:0] h;
		for (int t = 0; t < 3; t++) begin
			sc[5*t+:5] = manual_size_valid[t] ? manual_size[5*t+:5] :
				ref_size({width_sense_a[t], width_sense_b[t], width_sense_c[t], length_sense[t]}, north);
			sv[t] = sc[5*t+:5] != 5'h00;
			h = height_sense_n[4*t+:4];
			nb[t] = !h[0];
			lv[7*t+:7] = !h[1] ? `TPLS_LEVEL_10 : !h[2] ? `TPLS_LEVEL_30 : !h[3] ? `TPLS_LEVEL_70 : `TPLS_LEVEL_FULL;
		end
		return {sc, sv, lv, nb, ~paper_end_light};
	endfunction
	task step();
		repeat (24) @(posedge clk);
		#1;
		q.push_back(expect_all());
		->sample;
	endtask
	task set_pat(input int t, input [3:0] p);
		width_sense_a[t] <= p[3];
		width_sense_b[t] <= p[2];
		width_sense_c[t] <= p[1];
		length_sense[t] <= p[0];
	endtask
	task wrap_up();
		if (errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// monitor: oldest expectation against settled outputs
	always @(sample) begin
		`CHK({size_code, size_valid, level_pct, near_end, tray_empty}, q.pop_front())
	end
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 32; i++) begin
			@(posedge clk);
			n = $random(seed);
			north <= i[4];
			set_pat(0, i[3:0]);
			set_pat(1, n[3:0]);
			set_pat(2, n[7:4]);
			step();
		end
		@(posedge clk);
		set_pat(0, 4'hB);
		manual_size_valid <= 3'h1;
		manual_size <= {10'h000, `TPLS_SIZE_B5_SEF};
		step();
		@(posedge clk);
		manual_size_valid <= 3'h0;
		for (int k = 0; k < 5; k++) begin
			@(posedge clk);
			height_sense_n <= {3{4'hf >> k}};
			step();
		end
		@(posedge clk);
		paper_end_light <= 3'h6;
		repeat (2) @(posedge clk);
		paper_end_light <= 3'h7;
		step();
		@(posedge clk);
		paper_end_light <= 3'h6;
		level_drop <= 3'h1;
		@(posedge clk);
		level_drop <= 3'h0;
		repeat (80) @(posedge clk);
		`CHK(rev_n, 50)
		`CHK(fwd_n, 0)
		paper_end_light <= 3'h7;
		step();
		repeat (8) @(posedge clk);
		#1;
		`CHK(fwd_n > 0, 1'b1)
		`CHK(lift_forward[0], 1'b0)
		wrap_up();
	end
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		wrap_up();
	end
endmodule // tpls_tray_sense_tb_top
`default_nettype wire
